//--- iolp_defines.svh
// Constants for the I/O line configuration, PWM and sample report block
`ifndef IOLP_DEFINES_SVH
`define IOLP_DEFINES_SVH
`define IOLP_FN_DISABLED   3'h0
`define IOLP_FN_ALT1       3'h1
`define IOLP_FN_ALT2       3'h2
`define IOLP_FN_DIG_IN     3'h3
`define IOLP_FN_OUT_LOW    3'h4
`define IOLP_FN_OUT_HIGH   3'h5
`define IOLP_PULL_EN_RESET 15'h7fff
`define IOLP_PULL_DIR_RESET 15'h0000
`define IOLP_DUTY_MAX      10'h3ff
`define IOLP_PWM_PERIOD_PS 42620000
`define IOLP_CLK_PERIOD_PS 8000
`define IOLP_PWM_STEPS     1023
`define IOLP_SAMPLE_COUNT  8'h01
`define IOLP_ASCII_CR      8'h0d
`define IOLP_RESP_OK       8'h00
`define IOLP_RESP_ERROR    8'h01
`endif

//--- iolp_pkg.sv
// Types for the I/O line configuration, PWM and sample report block
package iolp_pkg;
  typedef enum logic [4:0] {
    IOLP_IDLE  = 5'b00001,
    IOLP_FIELD = 5'b00010,
    IOLP_CHAR  = 5'b00100,
    IOLP_ANA   = 5'b01000,
    IOLP_END   = 5'b10000
  } iolp_state_t;
endpackage

//--- iolp_io_block.sv
// I/O line configuration, pulls, PWM output and forced sample report
`timescale 1ns/1ps
`default_nettype none
`include "iolp_defines.svh"

// Behaviour
// - Setting 0 off, 3 input, 4/5 output
// - First PWM line: 1 signal PWM, 2 PWM
// - Fan enable low in sleep, saving, airplane
// - Direction bit 1 pull-up, 0 pull-down
// - Enable bit turns pull on; resets all ones
// - No pull on output, analog, disabled lines
// - Both fields share one line bit map
// - Duty 0..0x3ff proportional, 0x200 about half
// - PWM period 6138 clocks, about 49.1 us, 1023 steps
// - Temperature is 8-bit two's complement Celsius
// - Sample request errors with no digital or analog lines
// - Report: count, masks, digital data, analog readings
// - Analog readings are 10-bit converter values
// - Text: hex lines with CR, two CR end
// - Binary: 1,2,1 byte fields, 2-byte samples, MSB first
module iolp_io_block #(
  parameter int NLINES   = 13,
  parameter int NANALOG  = 4,
  parameter int PWM_DIV  = (`IOLP_PWM_PERIOD_PS / `IOLP_PWM_STEPS) / `IOLP_CLK_PERIOD_PS + 1
) (
  input  wire logic                 i_clk,            // 125 MHz clock
  input  wire logic                 i_arst_n,         // Async reset, active low
  input  wire logic [NLINES*3-1:0]  i_line_function,  // 3 bits per line, lines 0-9 then pwm 0-2
  input  wire logic                 i_apply,          // Apply pending settings pulse
  input  wire logic [14:0]          i_pull_enable_field,
  input  wire logic [14:0]          i_pull_direction_field,
  input  wire logic [9:0]           i_pwm_duty_setting,
  input  wire logic [9:0]           i_rssi_level,     // Signal strength as a duty value
  input  wire logic                 i_sleeping,
  input  wire logic                 i_power_saving,
  input  wire logic                 i_airplane,
  input  wire logic [NLINES-1:0]    i_line_in,        // Pin levels
  input  wire logic [9:0]           i_adc_data [NANALOG],
  input  wire logic [7:0]           i_temperature_raw,
  input  wire logic                 i_force_sample_request,
  input  wire logic                 i_binary_mode,
  output logic      [NLINES-1:0]    o_line_out,
  output logic      [NLINES-1:0]    o_line_oe,
  output logic      [14:0]          o_pull_on,
  output logic      [14:0]          o_pull_up,
  output logic      [7:0]           o_temperature_reading,
  output logic                      o_resp_valid,     // Acknowledge / error pulse
  output logic      [7:0]           o_resp_code,
  output logic                      o_rpt_valid,      // One report byte per pulse
  output logic      [7:0]           o_rpt_data,
  output logic                      o_rpt_last
);
  import iolp_pkg::*;

  // Pull bit position of each line (lines 0-9, pwm 0-2); 7 and 14 are serial lines
  localparam int PULL_BIT [13] = '{4, 3, 2, 1, 0, 8, 5, 13, 6, 9, 11, 12, 10};

  // Function code of line n
  function automatic logic [2:0] fn_of(input logic [NLINES*3-1:0] f, input int n);
    fn_of = f[n*3 +: 3];
  endfunction

  // Hex ASCII of a nibble
  function automatic logic [7:0] hex_char(input logic [3:0] v);
    hex_char = (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h57 + {4'h0, v};
  endfunction

  logic [NLINES*3-1:0] cfg;        // Applied settings
  logic [9:0]          duty;       // Applied duty
  logic [9:0]          pwm_cnt;    // Step counter
  logic [7:0]          pre_cnt;    // Step prescaler
  logic                pwm_output_zero;  // First PWM line compare
  logic                rssi_q;
  logic [15:0]         dmask;
  logic [7:0]          amask;
  logic [15:0]         ddata;

  // Settings latch on apply, duty only takes effect then
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg  <= '0;
      duty <= '0;
    end else if (i_apply) begin
      cfg  <= i_line_function;
      duty <= i_pwm_duty_setting;
    end
  end

  // Step prescaler and 1023-step period counter
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pre_cnt <= '0;
      pwm_cnt <= '0;
    end else if (pre_cnt == 8'(PWM_DIV - 1)) begin
      pre_cnt <= '0;
      pwm_cnt <= (pwm_cnt == 10'(`IOLP_PWM_STEPS - 1)) ? '0 : pwm_cnt + 10'h001;
    end else begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  // Compare; full scale stays high all period
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pwm_output_zero <= 1'b0;
      rssi_q          <= 1'b0;
    end else begin
      pwm_output_zero <= (duty == `IOLP_DUTY_MAX) || (pwm_cnt < duty);
      rssi_q <= (i_rssi_level == `IOLP_DUTY_MAX) || (pwm_cnt < i_rssi_level);
    end
  end

  // Line drivers, pulls and masks
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_line_out <= '0;
      o_line_oe  <= '0;
      o_pull_on  <= '0;
      o_pull_up  <= '0;
      dmask      <= '0;
      amask      <= '0;
      ddata      <= '0;
    end else begin
      o_pull_on <= '0;
      o_pull_up <= i_pull_direction_field;
      dmask     <= '0;
      amask     <= '0;
      for (int n = 0; n < NLINES; n++) begin
        o_line_out[n] <= 1'b0;
        o_line_oe[n]  <= 1'b0;
        case (fn_of(cfg, n))
          `IOLP_FN_DIG_IN: begin
            o_pull_on[PULL_BIT[n]] <= i_pull_enable_field[PULL_BIT[n]];
            dmask[n] <= 1'b1;
          end
          `IOLP_FN_OUT_LOW: begin
            o_line_oe[n] <= 1'b1;
            dmask[n] <= 1'b1;
          end
          `IOLP_FN_OUT_HIGH: begin
            o_line_out[n] <= 1'b1;
            o_line_oe[n]  <= 1'b1;
            dmask[n]      <= 1'b1;
          end
          `IOLP_FN_ALT1: begin
            if (n == 10) begin
              o_line_out[n] <= rssi_q;
              o_line_oe[n]  <= 1'b1;
            end else if (n == 11) begin
              o_line_out[n] <= !(i_sleeping || i_power_saving || i_airplane);
              o_line_oe[n]  <= 1'b1;
            end
          end
          `IOLP_FN_ALT2: begin
            if (n == 10) begin
              o_line_out[n] <= pwm_output_zero;
              o_line_oe[n]  <= 1'b1;
            end else if (n < NANALOG) begin
              amask[n] <= 1'b1;  // Analog input, never pulled
            end
          end
          default: begin
            // Disabled: undriven and unpulled
          end
        endcase
      end
      ddata <= 16'(i_line_in) & dmask;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_temperature_reading <= '0;
    end else begin
      o_temperature_reading <= i_temperature_raw;
    end
  end

  // Report sequencer: field 0 count, 1 dmask, 2 amask, 3 ddata, then analog
  iolp_state_t state;
  logic [2:0]  field;
  logic [1:0]  pos;      // Byte or nibble index within a field
  logic [2:0]  ach;      // Analog channel
  logic        bin;
  logic [15:0] fval;
  logic [1:0]  fmax;

  // Field value and last index (bytes or nibbles minus one)
  always_comb begin
    fval = 16'h0000;
    fmax = 2'd0;
    case (field)
      3'd0: begin fval = {8'h00, `IOLP_SAMPLE_COUNT}; fmax = bin ? 2'd0 : 2'd1; end
      3'd1: begin fval = dmask; fmax = bin ? 2'd1 : 2'd3; end
      3'd2: begin fval = {8'h00, amask}; fmax = bin ? 2'd0 : 2'd1; end
      3'd3: begin fval = ddata; fmax = bin ? 2'd1 : 2'd3; end
      default: begin fval = {6'h00, i_adc_data[ach[1:0]]}; fmax = bin ? 2'd1 : 2'd3; end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state        <= IOLP_IDLE;
      field        <= '0;
      pos          <= '0;
      ach          <= '0;
      bin          <= 1'b0;
      o_resp_valid <= 1'b0;
      o_resp_code  <= '0;
      o_rpt_valid  <= 1'b0;
      o_rpt_data   <= '0;
      o_rpt_last   <= 1'b0;
    end else begin
      o_resp_valid <= 1'b0;
      o_rpt_valid  <= 1'b0;
      o_rpt_last   <= 1'b0;
      case (state)
        IOLP_IDLE: begin
          if (i_force_sample_request) begin
            o_resp_valid <= 1'b1;
            bin          <= i_binary_mode;
            field        <= '0;
            pos          <= '0;
            ach          <= '0;
            if (dmask == '0 && amask == '0) begin
              o_resp_code <= `IOLP_RESP_ERROR;
            end else begin
              o_resp_code <= `IOLP_RESP_OK;
              state       <= IOLP_FIELD;
            end
          end
        end
        IOLP_FIELD: begin
          o_rpt_valid <= 1'b1;
          if (bin) begin
            o_rpt_data <= (pos == fmax) ? fval[7:0] : fval[15:8];
          end else begin
            o_rpt_data <= hex_char(fval[4*(fmax-pos) +: 4]);
          end
          if (pos != fmax) begin
            pos <= pos + 2'd1;
          end else if (!bin) begin
            state <= IOLP_CHAR;
          end else begin
            state <= IOLP_ANA;
          end
        end
        IOLP_CHAR: begin
          o_rpt_valid <= 1'b1;
          o_rpt_data  <= `IOLP_ASCII_CR;
          state       <= IOLP_ANA;
        end
        IOLP_ANA: begin
          // Pick next field: skip ddata when no digital lines, skip unset analog
          pos   <= '0;
          state <= IOLP_FIELD;
          if (field == 3'd2 && dmask == '0) begin
            field <= 3'd4;
            ach   <= '0;
            if (!amask[0]) state <= IOLP_ANA;
          end else if (field < 3'd3) begin
            field <= field + 3'd1;
          end else begin
            if (field == 3'd4) ach <= ach + 3'd1;
            field <= 3'd4;
            if (field == 3'd3) begin
              ach <= '0;
              if (!amask[0]) state <= IOLP_ANA;
            end else if (ach + 3'd1 >= 3'(NANALOG)) begin
              state <= IOLP_END;
            end else if (!amask[ach+3'd1]) begin
              state <= IOLP_ANA;
            end
            if (field == 3'd3 && NANALOG == 0) state <= IOLP_END;
          end
          if (field == 3'd4 && ach + 3'd1 >= 3'(NANALOG)) state <= IOLP_END;
          if (field == 3'd3 && amask == '0) state <= IOLP_END;
          if (field == 3'd2 && dmask == '0 && amask == '0) state <= IOLP_END;
        end
        IOLP_END: begin
          // Text adds a second CR; binary just marks the end
          if (!bin) begin
            o_rpt_valid <= 1'b1;
            o_rpt_data  <= `IOLP_ASCII_CR;
          end
          o_rpt_last <= 1'b1;
          state      <= IOLP_IDLE;
        end
        default: state <= IOLP_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- iolp_io_block_props.sv
// Port checks for the I/O line block
`timescale 1ns/1ps
`default_nettype none
`include "iolp_defines.svh"
module iolp_io_block_props #(
  parameter int NLINES = 13
) (
  input wire logic                i_clk,
  input wire logic                i_arst_n,
  input wire logic [NLINES*3-1:0] i_line_function,
  input wire logic                i_apply,
  input wire logic [9:0]          i_pwm_duty_setting,
  input wire logic                i_sleeping,
  input wire logic                i_power_saving,
  input wire logic                i_airplane,
  input wire logic                i_force_sample_request,
  input wire logic                i_binary_mode,
  input wire logic [NLINES-1:0]   o_line_out,
  input wire logic [NLINES-1:0]   o_line_oe,
  input wire logic                o_resp_valid,
  input wire logic [7:0]          o_resp_code,
  input wire logic                o_rpt_valid,
  input wire logic [7:0]          o_rpt_data,
  input wire logic                o_rpt_last
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic [2:0] fn0, fn10, fn11; // Applied functions
  logic [9:0] duty;            // Applied duty
  wire logic  asleep = i_sleeping | i_power_saving | i_airplane;
  // Shadow of applied settings; pending edits must not trip checks
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {fn0, fn10, fn11, duty} <= '0;
    end else if (i_apply) begin
      {fn0, fn10, fn11} <= {i_line_function[2:0], i_line_function[32:27+3], i_line_function[35:33]};
      duty <= i_pwm_duty_setting;
    end
  end
  chk_ack_on_req: assert property (o_resp_valid |-> $past(i_force_sample_request))
    else $error("ack without request");
  chk_bin_count_first: assert property (o_resp_valid && o_resp_code == `IOLP_RESP_OK && i_binary_mode
    |=> o_rpt_valid && o_rpt_data == `IOLP_SAMPLE_COUNT) else $error("bad first byte");
  chk_err_silent: assert property (o_resp_valid && o_resp_code == `IOLP_RESP_ERROR
    |=> !o_rpt_valid [*4]) else $error("report after error");
  chk_text_end_cr: assert property (o_rpt_last && !i_binary_mode
    |-> o_rpt_valid && o_rpt_data == `IOLP_ASCII_CR) else $error("text end not CR");
  chk_input_undriven: assert property ((fn0 == `IOLP_FN_DIG_IN) [*3] |-> !o_line_oe[0])
    else $error("input line driven");
  chk_output_level: assert property ((fn0 == `IOLP_FN_OUT_HIGH) [*3] |-> o_line_oe[0] && o_line_out[0])
    else $error("output start level wrong");
  chk_fan_off: assert property ((fn11 == `IOLP_FN_ALT1 && asleep) [*3] |-> !o_line_out[11])
    else $error("fan on while asleep");
  chk_full_duty: assert property ((fn10 == `IOLP_FN_ALT2 && duty == `IOLP_DUTY_MAX) [*3]
    |-> o_line_out[10]) else $error("full duty not high");
  cover property (o_rpt_last && i_binary_mode);
  cover property (o_resp_valid && o_resp_code == `IOLP_RESP_ERROR);
  cover property (fn11 == `IOLP_FN_ALT1 && asleep);
endmodule
bind iolp_io_block iolp_io_block_props #(.NLINES(NLINES)) i_iolp_io_block_props (.i_clk, .i_arst_n,
  .i_line_function, .i_apply, .i_pwm_duty_setting, .i_sleeping, .i_power_saving, .i_airplane,
  .i_force_sample_request, .i_binary_mode, .o_line_out, .o_line_oe, .o_resp_valid, .o_resp_code,
  .o_rpt_valid, .o_rpt_data, .o_rpt_last);
`default_nettype wire

//--- iolp_host_model.sv
// Host side: issues sample requests and gathers the report
`timescale 1ns/1ps
`default_nettype none
module iolp_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_resp_valid,
  input  wire logic [7:0] i_resp_code,
  input  wire logic       i_rpt_valid,
  input  wire logic [7:0] i_rpt_data,
  output logic            o_request
);
  logic [7:0] rx[$];  // Report bytes in order
  logic [7:0] resp;   // Last response code
  initial o_request = 1'b0;
  // One-cycle request; waits out the whole report before returning
  task automatic request();
    rx.delete();
    resp = 8'hee;
    @(posedge i_clk);
    o_request <= 1'b1;
    @(posedge i_clk);
    o_request <= 1'b0;
    repeat (60) @(posedge i_clk);
  endtask
  // Pulses stand one cycle, so take them at every edge
  always @(posedge i_clk) begin
    if (i_resp_valid) resp = i_resp_code;
    if (i_rpt_valid) rx.push_back(i_rpt_data);
  end
endmodule
`default_nettype wire

//--- iolp_io_block_tb_top.sv
// Self-checking bench for the I/O line block
`timescale 1ns/1ps
`default_nettype none
module iolp_io_block_tb_top;
  `define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
  logic i_clk = 0, i_arst_n = 0, i_apply = 0, i_binary_mode = 0;
  logic i_sleeping = 0, i_power_saving = 0, i_airplane = 0, i_force_sample_request;
  logic [38:0] i_line_function = '0;
  logic [14:0] i_pull_enable_field = 15'h7fff, i_pull_direction_field = 15'h0000;
  logic [9:0]  i_pwm_duty_setting = 0, i_rssi_level = 0;
  logic [12:0] i_line_in = 13'h0002, o_line_out, o_line_oe;
  logic [9:0]  i_adc_data [4] = '{10'h2a5, 10'h000, 10'h000, 10'h1ff};
  logic [7:0]  i_temperature_raw = 8'hf6, o_temperature_reading, o_resp_code, o_rpt_data;
  logic [14:0] o_pull_on, o_pull_up;
  logic        o_resp_valid, o_rpt_valid, o_rpt_last;
  int          num_errors = 0, checks = 0;
  always #4 i_clk = ~i_clk;
  iolp_io_block i_iolp_io_block (.i_clk, .i_arst_n, .i_line_function, .i_apply,
    .i_pull_enable_field, .i_pull_direction_field, .i_pwm_duty_setting, .i_rssi_level,
    .i_sleeping, .i_power_saving, .i_airplane, .i_line_in, .i_adc_data, .i_temperature_raw,
    .i_force_sample_request, .i_binary_mode, .o_line_out, .o_line_oe, .o_pull_on, .o_pull_up,
    .o_temperature_reading, .o_resp_valid, .o_resp_code, .o_rpt_valid, .o_rpt_data, .o_rpt_last);
  iolp_host_model i_iolp_host_model (.i_clk, .i_resp_valid(o_resp_valid), .i_resp_code(o_resp_code),
    .i_rpt_valid(o_rpt_valid), .i_rpt_data(o_rpt_data), .o_request(i_force_sample_request));
  // Settings then an apply pulse; outputs land two edges later
  task automatic set_fn(input logic [38:0] f);
    @(posedge i_clk);
    i_line_function <= f;
    i_apply <= 1;
    @(posedge i_clk);
    i_apply <= 0;
    repeat (4) @(posedge i_clk);
  endtask
  // Pull masking for output and analog lines, and the bit map
  task automatic t_pulls();
    i_pull_direction_field <= 15'h5555;
    set_fn({{8{3'h3}}, 3'h4, {3{3'h3}}, 3'h2});
    `CHK(o_pull_on, 15'h3f6e)
    `CHK(o_pull_up & o_pull_on, 15'h1544)
    i_pull_enable_field <= 15'h0200;
    repeat (3) @(posedge i_clk);
    `CHK(o_pull_on, 15'h0200)
  endtask
  // High cycles of the first PWM line across one period of 6138 clocks
  task automatic t_pwm(input logic [2:0] f, input logic [9:0] d, input int lo, hi);
    int n, r;
    logic prev;
    n = 0;
    r = 0;
    i_pwm_duty_setting <= d;
    i_rssi_level <= d;
    set_fn({6'h00, f, 30'h0});
    prev = o_line_out[10];
    // One whole period holds exactly one rising edge unless held high
    repeat (6138) begin
      @(posedge i_clk);
      n += o_line_out[10];
      r += int'(o_line_out[10] && !prev);
      prev = o_line_out[10];
    end
    `CHK((n >= lo && n <= hi), 1'b1)
    `CHK(r, int'(d != 10'h3ff))
  endtask
  // Error with no inputs, then binary and text reports
  task automatic t_sample();
    logic [7:0] e [10];
    e = '{8'h01, 8'h00, 8'h02, 8'h09, 8'h00, 8'h02, 8'h02, 8'ha5, 8'h01, 8'hff};
    set_fn('0);
    i_iolp_host_model.request();
    `CHK(i_iolp_host_model.resp, 8'h01)
    set_fn({27'h0, 3'h2, 3'h0, 3'h3, 3'h2});
    i_binary_mode <= 1;
    i_iolp_host_model.request();
    `CHK(i_iolp_host_model.resp, 8'h00)
    foreach (e[k]) `CHK(i_iolp_host_model.rx[k], e[k])
    i_binary_mode <= 0;
    i_iolp_host_model.request();
    `CHK({i_iolp_host_model.rx[0], i_iolp_host_model.rx[2]}, 16'h300d)
    `CHK({i_iolp_host_model.rx[$-1], i_iolp_host_model.rx[$]}, 16'h0d0d)
  endtask
  task automatic give_verdict();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1;
    set_fn({{10{3'h4}}, 3'h3, 3'h0, 3'h5});
    `CHK({o_line_oe, o_line_out}, 26'h3ff2001)
    `CHK(o_temperature_reading, 8'hf6)
    $display("test lines done");
    t_pulls();
    $display("test pulls done");
    t_pwm(3'h2, 10'h3ff, 6138, 6138);
    t_pwm(3'h2, 10'h200, 3060, 3084);
    t_pwm(3'h1, 10'h3ff, 6138, 6138);
    $display("test pwm done");
    set_fn({3'h0, 3'h1, 33'h0});
    for (int i = 0; i < 4; i++) begin
      {i_sleeping, i_power_saving, i_airplane} <= 3'b100 >> i;
      repeat (4) @(posedge i_clk);
      `CHK(o_line_out[11], (i == 3))
    end
    $display("test fan done");
    t_sample();
    $display("test sample done");
    give_verdict();
  end
  // Cut a hang short
  initial begin
    #(8 * 40000);
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
